// [design/qcr_regs.vh]
/*
 * Command codes, field positions, reset values and read-back constants for
 * the per-channel codec configuration register bank.
 * Assumes the includer uses the codes and values as 3-, 5-, 8- or 16-bit quantities.
 */
`ifndef QCR_REGS_VH
`define QCR_REGS_VH

// ----------------------------------------------------------------------
// Command codes (bit 0 selects read)
// ----------------------------------------------------------------------
`define QCR_CMD_PIN_DIR 8'h54
`define QCR_CMD_OP_FUNC 8'h60
`define QCR_CMD_INT_MASK 8'h6C
`define QCR_CMD_OP_COND 8'h70
`define QCR_CMD_REVISION 8'h73
`define QCR_CMD_TX_GAIN 8'h80
`define QCR_CMD_RX_GAIN 8'h82
`define QCR_CMD_RD_BIT 0

// ----------------------------------------------------------------------
// Per-channel write selects
// ----------------------------------------------------------------------
`define QCR_SEL_PIN_DIR 3'h0
`define QCR_SEL_OP_FUNC 3'h1
`define QCR_SEL_OP_COND 3'h2
`define QCR_SEL_TX_GAIN 3'h3
`define QCR_SEL_RX_GAIN 3'h4
`define QCR_SEL_NONE 3'h7

// ----------------------------------------------------------------------
// Pin direction / status field positions
// ----------------------------------------------------------------------
`define QCR_PDS_ACTIVE 6
`define QCR_PDS_SYNC_LOST 5
`define QCR_PDS_DIR_W 5

// ----------------------------------------------------------------------
// Operating functions field positions
// ----------------------------------------------------------------------
`define QCR_OF_LINEAR 7
`define QCR_OF_MULAW 6
`define QCR_OF_RX_GAIN_SEL 5
`define QCR_OF_TX_GAIN_SEL 4
`define QCR_OF_TX_EQ_SEL 3
`define QCR_OF_RX_EQ_SEL 2
`define QCR_OF_IMP_SEL 1
`define QCR_OF_BAL_SEL 0

// ----------------------------------------------------------------------
// Operating conditions field positions
// ----------------------------------------------------------------------
`define QCR_OC_TX_CUTOFF 7
`define QCR_OC_RX_CUTOFF 6
`define QCR_OC_HPF_BYPASS 5
`define QCR_OC_RX_LOSS 4
`define QCR_OC_TX_INT_ARM 3
`define QCR_OC_SLOT_LOOP 2
`define QCR_OC_FULL_LOOP 1
`define QCR_OC_TONE 0

// ----------------------------------------------------------------------
// Reset values and default coefficient store
// ----------------------------------------------------------------------
`define QCR_RST_PIN_DIR 5'h00
`define QCR_RST_OP_FUNC 8'h00
`define QCR_RST_INT_MASK 8'hFF
`define QCR_RST_OP_COND 8'h00
`define QCR_RST_TX_GAIN 16'hA9F0
`define QCR_RST_RX_GAIN 16'h23A1
`define QCR_ROM_TX_GAIN 16'hA9F0
`define QCR_ROM_RX_GAIN 16'h23A1
`define QCR_RD_NONE 8'h00

`endif

// [design/qcr_chan_regs.v]
/*
 * One channel's writable configuration: pin directions, operating
 * functions, operating conditions and the two gain coefficients, plus the
 * registered effective values that the signal path consumes.
 * Assumes the parent decodes commands and gates writes by channel enable.
 */
`include "qcr_regs.vh"

module qcr_chan_regs #(
   parameter CTRL_PINS = 5
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Write request
   input wire wr_en,
   input wire [2:0] wr_sel,
   input wire [15:0] wr_data,
   // Stored registers
   output reg [4:0] pin_dir_q,
   output reg [7:0] op_func_q,
   output reg [7:0] op_cond_q,
   output reg [15:0] tx_gain_prog_q,
   output reg [15:0] rx_gain_prog_q,
   // Effective values
   output reg [15:0] tx_gain_use_q,
   output reg [15:0] rx_gain_use_q,
   output reg balance_on_q
);

   // ----------------------------------------------------------------------
   // Pins that exist in this variant
   // ----------------------------------------------------------------------
   localparam [4:0] DIR_MASK = 5'h1F >> (5 - CTRL_PINS);

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_dir_q <= `QCR_RST_PIN_DIR;
         op_func_q <= `QCR_RST_OP_FUNC;
         op_cond_q <= `QCR_RST_OP_COND;
         tx_gain_prog_q <= `QCR_RST_TX_GAIN;
         rx_gain_prog_q <= `QCR_RST_RX_GAIN;
      end else if (wr_en) begin
         case (wr_sel)
            `QCR_SEL_PIN_DIR: begin
               // Status positions dropped, absent pins stay input
               pin_dir_q <= wr_data[4:0] & DIR_MASK;
            end
            `QCR_SEL_OP_FUNC: begin
               op_func_q <= wr_data[7:0];
            end
            `QCR_SEL_OP_COND: begin
               op_cond_q <= wr_data[7:0];
            end
            `QCR_SEL_TX_GAIN: begin
               tx_gain_prog_q <= wr_data;
            end
            `QCR_SEL_RX_GAIN: begin
               rx_gain_prog_q <= wr_data;
            end
            default: begin
               pin_dir_q <= pin_dir_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Default store versus programmed store, never overwriting either
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_gain_use_q <= `QCR_ROM_TX_GAIN;
         rx_gain_use_q <= `QCR_ROM_RX_GAIN;
         balance_on_q <= 1'b1;
      end else begin
         tx_gain_use_q <= op_func_q[`QCR_OF_TX_GAIN_SEL] ?
                          tx_gain_prog_q : `QCR_ROM_TX_GAIN;
         rx_gain_use_q <= op_func_q[`QCR_OF_RX_GAIN_SEL] ?
                          rx_gain_prog_q : `QCR_ROM_RX_GAIN;
         balance_on_q <= ~op_cond_q[`QCR_OC_RX_CUTOFF];
      end
   end

endmodule // qcr_chan_regs

// [design/qcr_config_bank.v]
/*
 * Four-channel codec configuration and status register bank behind the
 * byte-wide host command port: command decode, per-channel writes gated by
 * channel command enables, read-back, input-change interrupt and revision.
 * Assumes host bytes arrive as one-cycle strobes synchronous to clk and
 * that channel enables, status and real-time bits come from the core.
 */
`include "qcr_regs.vh"

module qcr_config_bank #(
   parameter CHANNELS = 4,
   parameter CTRL_PINS = 5,
   parameter [7:0] REVISION = 8'h01 // Arbitrary value
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Host command port
   input wire cmd_strobe,
   input wire data_strobe,
   input wire [7:0] host_byte,
   output reg rd_valid_q,
   output reg [7:0] rd_byte_q,
   // Channel state from the core
   input wire [CHANNELS-1:0] channel_command_enable,
   input wire [CHANNELS-1:0] channel_active_flag,
   input wire clock_sync_lost_flag,
   // Real-time inputs and interrupt
   input wire [2*CHANNELS-1:0] realtime_input_bit,
   input wire int_clear,
   output reg int_out_n_q,
   output reg [2*CHANNELS-1:0] input_change_mask_q,
   // Control pin directions, five per channel
   output wire [5*CHANNELS-1:0] pin_direction,
   // Operating functions, per channel
   output wire [CHANNELS-1:0] coding_linear,
   output wire [CHANNELS-1:0] coding_mulaw,
   output wire [CHANNELS-1:0] rx_gain_filter_select,
   output wire [CHANNELS-1:0] tx_gain_filter_select,
   output wire [CHANNELS-1:0] tx_equalizer_select,
   output wire [CHANNELS-1:0] rx_equalizer_select,
   output wire [CHANNELS-1:0] impedance_filter_select,
   output wire [CHANNELS-1:0] balance_filter_select,
   // Operating conditions, per channel
   output wire [CHANNELS-1:0] tx_path_cutoff,
   output wire [CHANNELS-1:0] rx_path_cutoff,
   output wire [CHANNELS-1:0] balance_filter_on,
   output wire [CHANNELS-1:0] tx_highpass_bypass,
   output wire [CHANNELS-1:0] rx_loss_insert,
   output wire [CHANNELS-1:0] tx_interrupt_arm,
   output wire [CHANNELS-1:0] slot_interface_loopback,
   output wire [CHANNELS-1:0] full_digital_loopback,
   output wire [CHANNELS-1:0] test_tone_enable,
   // Effective gain coefficients, sixteen bits per channel
   output wire [16*CHANNELS-1:0] transmit_gain_filter,
   output wire [16*CHANNELS-1:0] receive_gain_filter
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg [7:0] cmd_q;
   reg cmd_live_q;
   reg [1:0] byte_idx_q;
   reg [7:0] stage_q;
   reg [CHANNELS-1:0] chan_en_q;
   reg [2*CHANNELS-1:0] rt_prev_q;
   reg int_pend_q;
   reg int_pend_d;
   reg [2:0] wr_sel;
   reg [15:0] wr_data;
   reg wr_go;
   reg [15:0] rd_word;
   reg rd_wide;
   reg [7:0] rd_pick;
   wire [7:0] cmd_base;
   wire cmd_is_rd;
   wire [5*CHANNELS-1:0] pin_dir_all;
   wire [8*CHANNELS-1:0] op_func_all;
   wire [8*CHANNELS-1:0] op_cond_all;
   wire [16*CHANNELS-1:0] tx_prog_all;
   wire [16*CHANNELS-1:0] rx_prog_all;
   wire [2*CHANNELS-1:0] rt_change;
   integer rd_ch;
   genvar gi;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Lowest enabled channel, or CHANNELS when none
   function integer first_enabled;
      input [CHANNELS-1:0] en;
      integer k;
      begin
         first_enabled = CHANNELS;
         for (k = CHANNELS - 1; k >= 0; k = k - 1) begin
            if (en[k]) begin
               first_enabled = k;
            end
         end
      end
   endfunction

   // Command with the read bit cleared
   function [7:0] base_of;
      input [7:0] cmd;
      begin
         base_of = {cmd[7:1], 1'b0};
      end
   endfunction

   assign cmd_base = base_of(cmd_q);
   assign cmd_is_rd = cmd_q[`QCR_CMD_RD_BIT];

   // ----------------------------------------------------------------------
   // Command capture and byte counting
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= 8'h00;
         cmd_live_q <= 1'b0;
         byte_idx_q <= 2'h0;
         stage_q <= 8'h00;
         chan_en_q <= {CHANNELS{1'b0}};
      end else if (cmd_strobe) begin
         cmd_q <= host_byte;
         cmd_live_q <= 1'b1;
         byte_idx_q <= 2'h0;
         chan_en_q <= channel_command_enable;
      end else if (data_strobe && cmd_live_q) begin
         if (byte_idx_q == 2'h0) begin
            stage_q <= host_byte;
         end
         if (byte_idx_q != 2'h3) begin
            byte_idx_q <= byte_idx_q + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   always @* begin
      wr_sel = `QCR_SEL_NONE;
      wr_data = {8'h00, host_byte};
      wr_go = 1'b0;
      if (data_strobe && cmd_live_q && !cmd_is_rd && !cmd_strobe) begin
         case (cmd_base)
            `QCR_CMD_PIN_DIR: begin
               wr_sel = `QCR_SEL_PIN_DIR;
               wr_go = (byte_idx_q == 2'h0);
            end
            `QCR_CMD_OP_FUNC: begin
               wr_sel = `QCR_SEL_OP_FUNC;
               wr_go = (byte_idx_q == 2'h0);
            end
            `QCR_CMD_OP_COND: begin
               wr_sel = `QCR_SEL_OP_COND;
               wr_go = (byte_idx_q == 2'h0);
            end
            `QCR_CMD_TX_GAIN: begin
               // High byte first, committed whole on the second
               wr_sel = `QCR_SEL_TX_GAIN;
               wr_data = {stage_q, host_byte};
               wr_go = (byte_idx_q == 2'h1);
            end
            `QCR_CMD_RX_GAIN: begin
               wr_sel = `QCR_SEL_RX_GAIN;
               wr_data = {stage_q, host_byte};
               wr_go = (byte_idx_q == 2'h1);
            end
            default: begin
               wr_go = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt mask register, independent of channel enables
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_change_mask_q <= {2*CHANNELS{1'b1}};
      end else if (data_strobe && cmd_live_q && !cmd_is_rd && !cmd_strobe &&
                   cmd_base == `QCR_CMD_INT_MASK &&
                   byte_idx_q == 2'h0) begin
         input_change_mask_q <= host_byte[2*CHANNELS-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Per-channel register sets
   // ----------------------------------------------------------------------
   generate
      for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
         qcr_chan_regs #(
            .CTRL_PINS(CTRL_PINS)
         ) u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .wr_en(wr_go & chan_en_q[gi]),
            .wr_sel(wr_sel),
            .wr_data(wr_data),
            .pin_dir_q(pin_dir_all[5*gi +: 5]),
            .op_func_q(op_func_all[8*gi +: 8]),
            .op_cond_q(op_cond_all[8*gi +: 8]),
            .tx_gain_prog_q(tx_prog_all[16*gi +: 16]),
            .rx_gain_prog_q(rx_prog_all[16*gi +: 16]),
            .tx_gain_use_q(transmit_gain_filter[16*gi +: 16]),
            .rx_gain_use_q(receive_gain_filter[16*gi +: 16]),
            .balance_on_q(balance_filter_on[gi])
         );
         assign pin_direction[5*gi +: 5] = pin_dir_all[5*gi +: 5];
         assign coding_linear[gi] = op_func_all[8*gi+`QCR_OF_LINEAR];
         assign coding_mulaw[gi] = op_func_all[8*gi+`QCR_OF_MULAW];
         assign rx_gain_filter_select[gi] =
            op_func_all[8*gi+`QCR_OF_RX_GAIN_SEL];
         assign tx_gain_filter_select[gi] =
            op_func_all[8*gi+`QCR_OF_TX_GAIN_SEL];
         assign tx_equalizer_select[gi] =
            op_func_all[8*gi+`QCR_OF_TX_EQ_SEL];
         assign rx_equalizer_select[gi] =
            op_func_all[8*gi+`QCR_OF_RX_EQ_SEL];
         assign impedance_filter_select[gi] =
            op_func_all[8*gi+`QCR_OF_IMP_SEL];
         assign balance_filter_select[gi] =
            op_func_all[8*gi+`QCR_OF_BAL_SEL];
         assign tx_path_cutoff[gi] = op_cond_all[8*gi+`QCR_OC_TX_CUTOFF];
         assign rx_path_cutoff[gi] = op_cond_all[8*gi+`QCR_OC_RX_CUTOFF];
         assign tx_highpass_bypass[gi] =
            op_cond_all[8*gi+`QCR_OC_HPF_BYPASS];
         assign rx_loss_insert[gi] = op_cond_all[8*gi+`QCR_OC_RX_LOSS];
         assign tx_interrupt_arm[gi] =
            op_cond_all[8*gi+`QCR_OC_TX_INT_ARM];
         assign slot_interface_loopback[gi] =
            op_cond_all[8*gi+`QCR_OC_SLOT_LOOP];
         assign full_digital_loopback[gi] =
            op_cond_all[8*gi+`QCR_OC_FULL_LOOP];
         assign test_tone_enable[gi] = op_cond_all[8*gi+`QCR_OC_TONE];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read-back selection
   // ----------------------------------------------------------------------
   always @* begin
      rd_ch = first_enabled(chan_en_q);
      rd_word = 16'h0000;
      rd_wide = 1'b0;
      case (cmd_base)
         `QCR_CMD_PIN_DIR: begin
            // Live status; sync-lost shows even with no channel enabled
            rd_word[`QCR_PDS_SYNC_LOST] = clock_sync_lost_flag;
            if (rd_ch < CHANNELS) begin
               rd_word[`QCR_PDS_ACTIVE] =
                  channel_active_flag[rd_ch];
               rd_word[`QCR_PDS_DIR_W-1:0] = pin_dir_all[5*rd_ch +: 5];
            end
         end
         `QCR_CMD_OP_FUNC: begin
            if (rd_ch < CHANNELS) begin
               rd_word[7:0] = op_func_all[8*rd_ch +: 8];
            end
         end
         `QCR_CMD_OP_COND: begin
            if (rd_ch < CHANNELS) begin
               rd_word[7:0] = op_cond_all[8*rd_ch +: 8];
            end
         end
         `QCR_CMD_INT_MASK: begin
            rd_word[2*CHANNELS-1:0] = input_change_mask_q;
         end
         base_of(`QCR_CMD_REVISION): begin
            rd_word[7:0] = REVISION;
         end
         `QCR_CMD_TX_GAIN: begin
            rd_wide = 1'b1;
            if (rd_ch < CHANNELS) begin
               rd_word = tx_prog_all[16*rd_ch +: 16];
            end
         end
         `QCR_CMD_RX_GAIN: begin
            rd_wide = 1'b1;
            if (rd_ch < CHANNELS) begin
               rd_word = rx_prog_all[16*rd_ch +: 16];
            end
         end
         default: begin
            rd_wide = 1'b0;
         end
      endcase
      if (rd_wide) begin
         rd_pick = (byte_idx_q == 2'h0) ? rd_word[15:8] :
                   (byte_idx_q == 2'h1) ? rd_word[7:0] : `QCR_RD_NONE;
      end else begin
         rd_pick = (byte_idx_q == 2'h0) ? rd_word[7:0] : `QCR_RD_NONE;
      end
   end

   // ----------------------------------------------------------------------
   // Read data out, one byte per data strobe
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
         rd_byte_q <= 8'h00;
      end else begin
         rd_valid_q <= data_strobe && cmd_live_q && cmd_is_rd && !cmd_strobe;
         if (data_strobe && cmd_live_q && cmd_is_rd && !cmd_strobe) begin
            rd_byte_q <= rd_pick;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Input-change interrupt, set wins over clear
   // ----------------------------------------------------------------------
   assign rt_change = (realtime_input_bit ^ rt_prev_q) &
                      ~input_change_mask_q;

   always @* begin
      int_pend_d = int_pend_q;
      if (int_clear) begin
         int_pend_d = 1'b0;
      end
      if (|rt_change) begin
         int_pend_d = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rt_prev_q <= {2*CHANNELS{1'b0}};
         int_pend_q <= 1'b0;
         int_out_n_q <= 1'b1;
      end else begin
         rt_prev_q <= realtime_input_bit;
         int_pend_q <= int_pend_d;
         int_out_n_q <= ~int_pend_d;
      end
   end

endmodule // qcr_config_bank

// [bench/qcr_config_bank_monitor.sv]
/* Checker on the register bank's ports.
   Assumes one clock and the active low asynchronous reset. */
module qcr_config_bank_monitor #(
   parameter CHANNELS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host port and interrupt
   input wire logic data_strobe,
   input wire logic rd_valid_q,
   input wire logic int_clear,
   input wire logic int_out_n_q,
   input wire logic [2*CHANNELS-1:0] realtime_input_bit,
   input wire logic [2*CHANNELS-1:0] input_change_mask_q,
   // Channel outputs
   input wire logic [CHANNELS-1:0] rx_path_cutoff,
   input wire logic [CHANNELS-1:0] balance_filter_on,
   input wire logic [CHANNELS-1:0] tx_gain_filter_select,
   input wire logic [CHANNELS-1:0] rx_gain_filter_select,
   input wire logic [16*CHANNELS-1:0] transmit_gain_filter,
   input wire logic [16*CHANNELS-1:0] receive_gain_filter
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_cause;
      !data_strobe |=> !rd_valid_q;
   endproperty
   a_rd_cause: assert property (p_rd_cause)
      else $error("read byte without a data byte");
   property p_balance;
      1'b1 |=> balance_filter_on == ~$past(rx_path_cutoff);
   endproperty
   a_balance: assert property (p_balance)
      else $error("balance filter not tied to receive cutoff");
   property p_tx_default;
      !tx_gain_filter_select[0] |=> transmit_gain_filter[15:0] == 16'hA9F0;
   endproperty
   a_tx_default: assert property (p_tx_default)
      else $error("transmit gain not from default store");
   property p_rx_default;
      !rx_gain_filter_select[3] |=> receive_gain_filter[63:48] == 16'h23A1;
   endproperty
   a_rx_default: assert property (p_rx_default)
      else $error("receive gain not from default store");
   property p_int_rise;
      $rose(int_out_n_q) |-> $past(int_clear);
   endproperty
   a_int_rise: assert property (p_int_rise)
      else $error("interrupt released without clear");
   property p_int_hold;
      !int_out_n_q && !int_clear |=> !int_out_n_q;
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("interrupt dropped by itself");
   property p_masked;
      input_change_mask_q == 8'hFF && int_out_n_q |=> int_out_n_q;
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked change raised interrupt");
   property p_fires;
      ((realtime_input_bit ^ $past(realtime_input_bit))
         & ~input_change_mask_q) != 0 |=> !int_out_n_q;
   endproperty
   a_fires: assert property (p_fires)
      else $error("unmasked change raised no interrupt");
endmodule // qcr_config_bank_monitor

bind qcr_config_bank qcr_config_bank_monitor #(.CHANNELS(CHANNELS)) mon (
   .clk, .rst_n, .data_strobe, .rd_valid_q, .int_clear, .int_out_n_q,
   .realtime_input_bit, .input_change_mask_q, .rx_path_cutoff,
   .balance_filter_on, .tx_gain_filter_select, .rx_gain_filter_select,
   .transmit_gain_filter, .receive_gain_filter
);

// [bench/qcr_host.sv]
/* Host model driving the byte-wide command port.
   Assumes strobes are taken at rising clk edges. */
module qcr_host (
   // Clock
   input wire logic clk,
   // Command port
   output logic cmd_strobe,
   output logic data_strobe,
   output logic [7:0] host_byte,
   input wire logic rd_valid_q,
   input wire logic [7:0] rd_byte_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rd_sh = 16'h0000;
   initial begin
      cmd_strobe = 1'b0;
      data_strobe = 1'b0;
      host_byte = 8'h00;
   end
   always @(posedge clk) begin
      if (rd_valid_q) begin
         rd_sh <= {rd_sh[7:0], rd_byte_q};
      end
   end
   // Command byte, then n data bytes, high byte first
   task automatic xfer(input logic [7:0] cmd, input int n,
                       input logic [15:0] wd, output logic [15:0] rd);
      @(posedge clk);
      cmd_strobe <= 1'b1;
      host_byte <= cmd;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cmd_strobe <= 1'b0;
         data_strobe <= 1'b1;
         host_byte <= (n == 2 && i == 0) ? wd[15:8] : wd[7:0];
      end
      @(posedge clk);
      data_strobe <= 1'b0;
      host_byte <= ~host_byte;
      @(posedge clk);
      #1 rd = (n == 2) ? rd_sh : {8'h00, rd_sh[7:0]};
   endtask
endmodule // qcr_host

// [bench/qcr_config_bank_bench.sv]
/* Self-checking bench for the register bank.
   Assumes the host model and the bound checker. */
module qcr_config_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, int_clear = 0, clock_sync_lost_flag = 0;
   logic [3:0] channel_command_enable = 4'hF, channel_active_flag = 0;
   logic [7:0] realtime_input_bit = 0;
   wire cmd_strobe, data_strobe, rd_valid_q, int_out_n_q;
   wire [7:0] host_byte, rd_byte_q, input_change_mask_q;
   wire [19:0] pin_direction;
   wire [3:0] balance_filter_on;
   wire [31:0] op_fn, op_cd;
   wire [63:0] transmit_gain_filter;
   logic [15:0] rd;
   int failures = 0, checks_done = 0;
   always #12.5 clk = ~clk;
   qcr_host host (.clk, .cmd_strobe, .data_strobe, .host_byte,
      .rd_valid_q, .rd_byte_q);
   qcr_config_bank DUT (.clk, .rst_n, .cmd_strobe, .data_strobe, .host_byte,
      .rd_valid_q, .rd_byte_q, .channel_command_enable, .channel_active_flag,
      .clock_sync_lost_flag, .realtime_input_bit, .int_clear, .int_out_n_q,
      .input_change_mask_q, .pin_direction,
      .coding_linear(op_fn[31:28]), .coding_mulaw(op_fn[27:24]),
      .rx_gain_filter_select(op_fn[23:20]),
      .tx_gain_filter_select(op_fn[19:16]),
      .tx_equalizer_select(op_fn[15:12]), .rx_equalizer_select(op_fn[11:8]),
      .impedance_filter_select(op_fn[7:4]),
      .balance_filter_select(op_fn[3:0]), .tx_path_cutoff(op_cd[31:28]),
      .rx_path_cutoff(op_cd[27:24]), .balance_filter_on,
      .tx_highpass_bypass(op_cd[23:20]), .rx_loss_insert(op_cd[19:16]),
      .tx_interrupt_arm(op_cd[15:12]),
      .slot_interface_loopback(op_cd[11:8]),
      .full_digital_loopback(op_cd[7:4]), .test_tone_enable(op_cd[3:0]),
      .transmit_gain_filter, .receive_gain_filter());
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] c, input int n, input logic [15:0] e);
      host.xfer(c, n, 16'h0000, rd);
      chk($sformatf("read %h", c), e, rd);
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      channel_active_flag <= 4'h1;
      clock_sync_lost_flag <= 1;
      rdc(8'h55, 1, 16'h0060);
      rdc(8'h61, 1, 16'h0000);
      rdc(8'h6D, 1, 16'h00FF);
      rdc(8'h71, 1, 16'h0000);
      rdc(8'h81, 2, 16'hA9F0);
      rdc(8'h83, 2, 16'h23A1);
      rdc(8'h73, 1, 16'h0001);
      channel_active_flag <= 0;
      clock_sync_lost_flag <= 0;
      host.xfer(8'h54, 1, 16'h001F, rd);
      rdc(8'h55, 1, 16'h001F);
      chk("pin_direction", 16'h001F, {11'h0, pin_direction[4:0]});
      channel_active_flag <= 4'h1;
      rdc(8'h55, 1, 16'h005F);
      channel_command_enable <= 4'h2;
      host.xfer(8'h60, 1, 16'h00FF, rd);
      chk("op_func", 32'h2222_2222, op_fn);
      channel_command_enable <= 4'h0;
      host.xfer(8'h6C, 1, 16'h0000, rd);
      rdc(8'h6D, 1, 16'h0000);
      rdc(8'h73, 1, 16'h0001);
      channel_command_enable <= 4'h1;
      host.xfer(8'h80, 2, 16'h1234, rd);
      host.xfer(8'h60, 1, 16'h0010, rd);
      chk("tx_gain", 16'h1234, transmit_gain_filter[15:0]);
      host.xfer(8'h60, 1, 16'h0000, rd);
      chk("tx_gain", 16'hA9F0, transmit_gain_filter[15:0]);
      rdc(8'h81, 2, 16'h1234);
      host.xfer(8'h82, 1, 16'h00AB, rd);
      rdc(8'h83, 2, 16'h23A1);
      for (int i = 0; i < 8; i++) begin
         host.xfer(8'h70, 1, 16'h0001 << i, rd);
         rdc(8'h71, 1, 16'h0001 << i);
         chk("op_cond", 32'h0000_0001 << 4*i, op_cd);
      end
      host.xfer(8'h70, 1, 16'h0040, rd);
      chk("balance_on", 16'h0000, {15'h0, balance_filter_on[0]});
      realtime_input_bit <= 8'h08;
      repeat (2) @(posedge clk);
      #1 chk("int_n", 16'h0000, {15'h0, int_out_n_q});
      int_clear <= 1;
      @(posedge clk);
      int_clear <= 0;
      @(posedge clk);
      #1 chk("int_n", 16'h0001, {15'h0, int_out_n_q});
      host.xfer(8'h6C, 1, 16'h00FF, rd);
      realtime_input_bit <= 8'h00;
      repeat (2) @(posedge clk);
      #1 chk("int_n", 16'h0001, {15'h0, int_out_n_q});
      close_out();
   end
endmodule // qcr_config_bank_bench
